// ---- tb/gsr_ctrl_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gsr_params.svh"
module gsr_ctrl_test;
   import gsr_pkg::*;
   // short sleep delay so the run stays brief
   localparam int SIM_DLY = 20;
   logic i_sys_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_cmd_pending = 1'b1;
   logic i_idle_tasks_busy = 1'b0;
   logic i_reg_wr = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   wire logic scl;
   wire logic sda;
   logic o_warm_reset;
   logic o_sleep;
   logic [31:0] o_state_word;
   gsr_state_type o_state;
   int n_fail = 0;
   int total_checks = 0;
   int wakes = 0;
   int cnt;
   always #5 i_sys_clk = ~i_sys_clk;
   // the x to 0 step at reset is not a wake
   always @(negedge o_sleep) if (i_arst_n) wakes++;
   gsr_host_model host (.o_scl(scl), .o_sda(sda));
   gsr_ctrl #(.SLEEP_DELAY_CYC(SIM_DLY)) uut (
      .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda),
      .i_cmd_pending(i_cmd_pending), .i_idle_tasks_busy(i_idle_tasks_busy),
      .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .o_warm_reset(o_warm_reset),
      .o_sleep(o_sleep), .o_state_word(o_state_word), .o_state(o_state));
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic wait_state(input gsr_state_type s);
      cnt = 0;
      while (o_state !== s && cnt < 100) begin
         @(negedge i_sys_clk);
         cnt++;
      end
   endtask : wait_state
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      check("state_word", o_state_word, 32'h8800_0000);
      check("sleep", {31'h0, o_sleep}, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_warm(input logic [7:0] addr, input int exp_len);
      i_reg_addr = addr;
      i_reg_wr = 1'b1;
      @(negedge i_sys_clk);
      i_reg_wr = 1'b0;
      cnt = 0;
      repeat (12) begin
         cnt += o_warm_reset;
         @(negedge i_sys_clk);
      end
      check("warm_len", cnt, exp_len);
      $display("test warm %h done", addr);
   endtask : t_warm
   task automatic t_abort();
      i_cmd_pending = 1'b0;
      wait_state(GSR_COUNTDOWN);
      repeat (5) @(negedge i_sys_clk);
      i_reg_addr = 8'h10;
      i_reg_wr = 1'b1;
      @(negedge i_sys_clk);
      i_reg_wr = 1'b0;
      i_cmd_pending = 1'b1;
      check("abort_state", {29'h0, o_state}, {29'h0, GSR_ACTIVE});
      check("abort_warm", {31'h0, o_warm_reset}, 32'h0);
      repeat (30) @(negedge i_sys_clk);
      check("held_state", {29'h0, o_state}, {29'h0, GSR_ACTIVE});
      $display("test abort done");
   endtask : t_abort
   task automatic t_sleep();
      i_cmd_pending = 1'b0;
      i_idle_tasks_busy = 1'b1;
      wait_state(GSR_COUNTDOWN);
      check("countdown", {29'h0, o_state}, {29'h0, GSR_COUNTDOWN});
      wait_state(GSR_GO_SLEEP);
      check("delay_len", cnt, SIM_DLY);
      repeat (6) @(negedge i_sys_clk);
      check("go_sleep", {29'h0, o_state}, {29'h0, GSR_GO_SLEEP});
      check("not_asleep", {31'h0, o_sleep}, 32'h0);
      i_idle_tasks_busy = 1'b0;
      repeat (4) @(negedge i_sys_clk);
      check("asleep", {31'h0, o_sleep}, 32'h1);
      check("sleep_state", {29'h0, o_state}, {29'h0, GSR_SLEEP});
      check("state_word_idle", o_state_word, 32'h0800_0000);
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_wake();
      host.send_addr(8'h62);
      check("other_addr", wakes, 0);
      check("still_asleep", {31'h0, o_sleep}, 32'h1);
      host.send_addr(8'h61);
      check("own_addr", wakes, 1);
      $display("test wake done");
   endtask : t_wake
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      #600000;
      n_fail++;
      close_out();
   end
   initial begin
      repeat (16) @(negedge i_sys_clk);
      i_arst_n = 1'b1;
      repeat (3) @(negedge i_sys_clk);
      t_reset();
      t_warm(`GSR_WARM_RST_REG, `GSR_WARM_RST_CYC);
      t_warm(8'h87, 0);
      t_abort();
      t_sleep();
      t_wake();
      close_out();
   end
endmodule : gsr_ctrl_test
`default_nettype wire

// ---- tb/gsr_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// serial bus host, both lines driven high and low directly, no pull-up
// ----------------------------------------
module gsr_host_model (
   // bus pins seen by the device
   output logic o_scl,
   output logic o_sda
);
   realtime last_stop;
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
      last_stop = -50000.0;
   end
   // start, address byte msb first, ack slot released, stop
   task automatic send_addr(input logic [7:0] byte_val);
      integer i;
      if ($realtime - last_stop < 50000.0) #(50000.0 - ($realtime - last_stop));
      o_sda = 1'b0;
      #500 o_scl = 1'b0;
      for (i = 7; i >= 0; i--) begin
         o_sda = byte_val[i];
         #500 o_scl = 1'b1;
         #500 o_scl = 1'b0;
      end
      // released line is driven high by the host
      o_sda = 1'b1;
      #500 o_scl = 1'b1;
      #500 o_scl = 1'b0;
      o_sda = 1'b0;
      #500 o_scl = 1'b1;
      #500 o_sda = 1'b1;
      last_stop = $realtime;
   endtask : send_addr
endmodule : gsr_host_model
`default_nettype wire

// ---- verilog/gsr_ctrl.sv ----
// Contract
// - Any write to the warm-restart register, whatever its data, causes a warm reset.
// - The warm-restart register is optional and its presence shows as a state word flag; the flag reads 0 until the first clock after reset.
// - Once idle the device starts counting down the configurable sleep delay.
// - When the countdown expires the device enters the go-to-sleep procedure.
// - Sleep is entered only once idle tasks are done and no command is pending.
// - While sleeping the device wakes as soon as its own address is seen on the bus.
// - The default target address is 0x30 and that address wakes the device.
`timescale 1ns/1ns
`default_nettype none
`include "gsr_params.svh"
module gsr_ctrl #(
   parameter int SLEEP_DELAY_CYC = `GSR_SLEEP_DELAY_US * `GSR_CLK_MHZ,
   parameter bit WARM_RST_PRESENT = 1'b1,
   parameter logic [6:0] TARGET_ADDR = `GSR_BASE_ADDR
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // serial bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   // device core status
   input wire logic i_cmd_pending,
   input wire logic i_idle_tasks_busy,
   // decoded register write from the transport
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   // outputs
   output logic o_warm_reset,
   output logic o_sleep,
   output logic [31:0] o_state_word,
   output gsr_pkg::gsr_state_type o_state
);
   import gsr_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic scl_s;
   logic sda_s;
   gsr_sync u_scl (
      .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_pin(i_scl),
      .o_level(scl_s)
   );
   gsr_sync u_sda (
      .i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n),
      .i_pin(i_sda),
      .o_level(sda_s)
   );

   // ----------------------------------------
   // address snoop for wake-up
   // ----------------------------------------
   // the bus is only watched, never driven here; a sleeping core
   // cannot ack, so waking on the address byte is enough
   logic scl_d_reg;
   logic sda_d_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic in_frame_reg;
   logic addr_hit_reg;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end
   wire start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   wire stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   wire scl_rise = scl_s && !scl_d_reg;
   wire [7:0] shift_next = {shift_reg[6:0], sda_s};
   wire byte_done = in_frame_reg && scl_rise && (bit_cnt_reg == 4'h7);
   wire addr_match = byte_done && (shift_next[7:1] == TARGET_ADDR);
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         in_frame_reg <= 1'b0;
         addr_hit_reg <= 1'b0;
      end else begin
         addr_hit_reg <= addr_match;
         if (start_det) begin
            in_frame_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
         end else if (stop_det || byte_done) begin
            in_frame_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            shift_reg <= shift_next;
         end else if (in_frame_reg && scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= shift_next;
         end
      end
   end

   // ----------------------------------------
   // warm reset
   // ----------------------------------------
   // any data value
   wire warm_hit = WARM_RST_PRESENT && i_reg_wr && (i_reg_addr == `GSR_WARM_RST_REG);
   logic [3:0] wr_cnt_reg;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_cnt_reg <= 4'h0;
         o_warm_reset <= 1'b0;
      end else begin
         if (warm_hit) begin
            wr_cnt_reg <= `GSR_WARM_RST_CYC;
         end else if (wr_cnt_reg != 4'h0) begin
            wr_cnt_reg <= wr_cnt_reg - 4'h1;
         end
         o_warm_reset <= warm_hit || (wr_cnt_reg > 4'h1);
      end
   end

   // ----------------------------------------
   // sleep state machine
   // ----------------------------------------
   gsr_state_type state_reg;
   gsr_state_type state_next;
   logic [31:0] dly_reg;
   wire busy = i_cmd_pending || i_reg_wr || o_warm_reset;
   wire dly_done = (dly_reg == 32'h0000_0001);
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         GSR_ACTIVE: begin
            if (!busy) begin
               state_next = GSR_COUNTDOWN;
            end
         end
         GSR_COUNTDOWN: begin
            if (busy) begin
               state_next = GSR_ACTIVE;
            end else if (dly_done) begin
               state_next = GSR_GO_SLEEP;
            end
         end
         GSR_GO_SLEEP: begin
            if (busy) begin
               state_next = GSR_ACTIVE;
            end else if (!i_idle_tasks_busy) begin
               state_next = GSR_SLEEP;
            end
         end
         GSR_SLEEP: begin
            if (addr_hit_reg || busy) begin
               state_next = GSR_ACTIVE;
            end
         end
         default: begin
            state_next = GSR_ACTIVE;
         end
      endcase
   end
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= GSR_ACTIVE;
         dly_reg <= 32'h0000_0000;
         o_sleep <= 1'b0;
         o_state <= GSR_ACTIVE;
         o_state_word <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         o_state <= state_next;
         o_sleep <= (state_next == GSR_SLEEP);
         if (state_next == GSR_COUNTDOWN && state_reg != GSR_COUNTDOWN) begin
            dly_reg <= 32'(SLEEP_DELAY_CYC);
         end else if (dly_reg != 32'h0000_0000) begin
            dly_reg <= dly_reg - 32'h0000_0001;
         end
         o_state_word <= 32'h0000_0000;
         o_state_word[`GSR_STATE_WARM_RST_BIT] <= WARM_RST_PRESENT;
         o_state_word[`GSR_STATE_BUSY_BIT] <= i_cmd_pending;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // full pulse length, retrigger only lengthens it
   chk_warm_rst_pulse: assert property (
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      warm_hit |=> o_warm_reset[*8])
      else $error("warm reset pulse too short");
   chk_wake_addr: assert property (
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (state_reg == GSR_SLEEP && addr_hit_reg) |=> !o_sleep)
      else $error("no wake on own address");
   chk_sleep_gate: assert property (
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (state_reg == GSR_GO_SLEEP && i_idle_tasks_busy) |=> !o_sleep)
      else $error("slept with idle tasks busy");
   chk_abandon_cmd: assert property (
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (state_reg == GSR_COUNTDOWN && busy) |=> state_reg == GSR_ACTIVE)
      else $error("countdown not abandoned");
   chk_expiry_to_proc: assert property (
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (state_reg == GSR_COUNTDOWN && dly_done && !busy) |=> state_reg == GSR_GO_SLEEP)
      else $error("expiry did not enter procedure");
   chk_idle_start: assert property (
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (state_reg == GSR_ACTIVE && !busy) |=> (state_reg == GSR_COUNTDOWN) && dly_reg != 0)
      else $error("countdown not started");
   chk_present_flag: assert property (
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      $past(i_arst_n) |-> o_state_word[`GSR_STATE_WARM_RST_BIT] == WARM_RST_PRESENT)
      else $error("presence flag wrong");
   chk_no_pending: assert property (
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(o_sleep) |-> !$past(i_cmd_pending))
      else $error("slept with command pending");
   cov_sleep: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) $rose(o_sleep));
   cov_wake: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) $fell(o_sleep));
   cov_warm: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) $rose(o_warm_reset));
endmodule : gsr_ctrl
`default_nettype wire

// ---- verilog/gsr_params.svh ----
`ifndef GSR_PARAMS_SVH
`define GSR_PARAMS_SVH
// bus target address, 7 bits
`define GSR_BASE_ADDR 7'h30
// warm-restart register address inside the device
`define GSR_WARM_RST_REG 8'h88
// sleep delay default in microseconds
`define GSR_SLEEP_DELAY_US 20000
`define GSR_CLK_MHZ 100
// warm reset pulse length in cycles
`define GSR_WARM_RST_CYC 4'h8
// bit position of the warm-restart flag in the interface state word
`define GSR_STATE_WARM_RST_BIT 27
`define GSR_STATE_BUSY_BIT 31
`endif

// ---- verilog/gsr_pkg.sv ----
`default_nettype none
package gsr_pkg;
   typedef enum logic [2:0] {
      GSR_ACTIVE,
      GSR_COUNTDOWN,
      GSR_GO_SLEEP,
      GSR_SLEEP
   } gsr_state_type;
endpackage : gsr_pkg
`default_nettype wire

// ---- verilog/gsr_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// three-stage pin synchroniser; a change counts once stages two and three agree
module gsr_sync (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // pin side
   input wire logic i_pin,
   // clean side
   output logic o_level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         o_level <= 1'b1;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            o_level <= s3_reg;
         end
      end
   end
endmodule : gsr_sync
`default_nettype wire
